// ---- cf_host_port.sv ----
/*
 * Card-side flow-control, strobe and status logic of the parallel host port:
 * cycle-stretch wait / IORDY, ultra dma write-ready and read strobe, write strobe
 * decode per personality, and the write-protect / 16-bit indication pin.
 * Assumes the core runs on clk_sys_in and host pins are asynchronous to it.
 */
`timescale 1ns/1ps
`include "cf_host_port_defs.svh"

module cf_host_port
   import cf_host_port_pkg::*;
(
   // clock and reset
   input  wire logic               clk_sys_in,
   input  wire logic               rstn_in,
   // core side: personality and status
   input  wire mode_e              mode_in,
   input  wire core_status_s       status_in,
   input  wire udma_ctrl_s         udma_in,
   // core side: read burst words
   input  wire word_s              rd_word_in,
   output logic                    rd_taken_out,
   // core side: write burst words and register strobes
   output word_s                   wr_word_out,
   output logic                    cfg_wr_out,
   output logic                    task_wr_out,
   // host pins: inputs
   input  wire logic               we_n_in,
   input  wire logic               dmack_n_in,
   input  wire logic               hstrobe_in,
   input  wire logic               hdmardy_n_in,
   input  wire logic [`DATA_W-1:0] data_in,
   // host pins: data bus drive
   output logic [`DATA_W-1:0]      data_out,
   output logic                    data_oe_out,
   // host pins: flow-control pin (wait / IORDY / write-ready / read strobe)
   output logic                    flow_out,
   output logic                    flow_oe_out,
   // host pins: status pin (write protect / 16-bit port / word transfer)
   output logic                    stat_out,
   output logic                    stat_oe_out
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   typedef enum logic [1:0] {
      RD_IDLE  = 2'b00,
      RD_SETUP = 2'b01,
      RD_HOLD  = 2'b10
   } rd_state_e;

   logic                 we_n_s;
   logic                 dmack_n_s;
   logic                 hstrobe_s;
   logic                 hdmardy_n_s;
   logic [`DATA_W-1:0]   data_s;
   logic                 we_n_d_ff;
   logic                 hstrobe_d_ff;
   logic                 we_fall;
   logic                 hstrobe_edge;
   rd_state_e            rd_state_ff;
   rd_state_e            nxt_rd_state;
   logic                 rd_take;
   logic                 tmr_start;
   logic [`TMR_W-1:0]    tmr_load;
   logic                 tmr_done;
   logic                 dstrobe_ff;
   logic                 nxt_flow;
   logic                 nxt_stat;
   logic                 udma_any;

   // strobe-type pins idle high, so reset the sync stages high
   sync_pin #(
      .WIDTH   (4),
      .RST_VAL (4'hF)
   ) u_sync_ctl (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .pin_in     ({we_n_in, dmack_n_in, hstrobe_in, hdmardy_n_in}),
      .sync_out   ({we_n_s, dmack_n_s, hstrobe_s, hdmardy_n_s})
   );

   // data passes the same two stages so it lines up with the host strobe
   sync_pin #(
      .WIDTH   (`DATA_W),
      .RST_VAL ('0)
   ) u_sync_data (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .pin_in     (data_in),
      .sync_out   (data_s)
   );

   // ************************************************************
   // edge detection on synchronised pins
   // ************************************************************
   // delayed copies for edge detection
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         we_n_d_ff    <= `PIN_HIGH;
         hstrobe_d_ff <= `PIN_HIGH;
      end else begin
         we_n_d_ff    <= we_n_s;
         hstrobe_d_ff <= hstrobe_s;
      end
   end

   assign we_fall      = we_n_d_ff & ~we_n_s;
   // either edge of the host strobe carries a word during a write burst
   assign hstrobe_edge = hstrobe_d_ff ^ hstrobe_s;
   assign udma_any     = udma_in.wr_active | udma_in.rd_active;

   // ************************************************************
   // write strobe decode per personality
   // ************************************************************
   // the core tells task from config writes only by mode; the address decode is its job
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cfg_wr_out  <= `PIN_LOW;
         task_wr_out <= `PIN_LOW;
      end else begin
         case (mode_in)
            MODE_MEM: begin
               cfg_wr_out  <= we_fall & ~udma_any;
               task_wr_out <= we_fall & ~udma_any;
            end
            MODE_IO: begin
               cfg_wr_out  <= we_fall & ~udma_any;
               task_wr_out <= `PIN_LOW;
            end
            default: begin
               cfg_wr_out  <= `PIN_LOW;
               task_wr_out <= `PIN_LOW;
            end
         endcase
      end
   end

   // ************************************************************
   // ultra dma write burst capture
   // ************************************************************
   // words already in flight when write-ready drops are still kept, so the core
   // must lower wr_can_accept with a few words of room left
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_word_out <= '0;
      end else begin
         wr_word_out.valid <= udma_in.wr_active & ~dmack_n_s & hstrobe_edge;
         if (udma_in.wr_active && hstrobe_edge) begin
            wr_word_out.data <= data_s;
         end
      end
   end

   // ************************************************************
   // ultra dma read burst sequencer
   // ************************************************************
   // the hold phase keeps each word on the bus past its strobe edge, so the
   // next take cannot overwrite data that the host is still latching
   // a word is taken only while the host acknowledges and is not pausing
   assign rd_take = (rd_state_ff == RD_IDLE) & udma_in.rd_active & ~dmack_n_s
                  & ~hdmardy_n_s & rd_word_in.valid;

   // next state and timer loads
   always_comb begin
      nxt_rd_state = rd_state_ff;
      tmr_start    = 1'h0;
      tmr_load     = '0;
      case (rd_state_ff)
         RD_IDLE: begin
            if (rd_take) begin
               nxt_rd_state = RD_SETUP;
               tmr_start    = 1'h1;
               tmr_load     = `TMR_W'(`RD_SETUP_CYC);
            end
         end
         RD_SETUP: begin
            if (!udma_in.rd_active) begin
               nxt_rd_state = RD_IDLE;
            end else if (tmr_done) begin
               nxt_rd_state = RD_HOLD;
               tmr_start    = 1'h1;
               tmr_load     = `TMR_W'(`RD_HOLD_CYC);
            end
         end
         RD_HOLD: begin
            if (tmr_done || !udma_in.rd_active) begin
               nxt_rd_state = RD_IDLE;
            end
         end
         default: begin
            nxt_rd_state = RD_IDLE;
         end
      endcase
   end

   phase_timer u_rd_timer (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .start_in   (tmr_start),
      .load_in    (tmr_load),
      .done_out   (tmr_done)
   );

   // sequencer state
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_state_ff <= RD_IDLE;
      end else begin
         rd_state_ff <= nxt_rd_state;
      end
   end

   // data bus: driven for the whole read burst; each word is loaded on its take
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         data_out     <= '0;
         data_oe_out  <= `PIN_LOW;
         rd_taken_out <= `PIN_LOW;
      end else begin
         rd_taken_out <= rd_take;
         data_oe_out  <= udma_in.rd_active;
         if (rd_take) begin
            data_out <= rd_word_in.data;
         end
      end
   end

   // strobe toggles once per word after setup; with no word it holds its level
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dstrobe_ff <= `PIN_HIGH;
      end else if (!udma_in.rd_active) begin
         dstrobe_ff <= `PIN_HIGH;  // bursts start from a high strobe
      end else if (rd_state_ff == RD_SETUP && tmr_done) begin
         dstrobe_ff <= ~dstrobe_ff;
      end
   end

   // ************************************************************
   // flow-control pin
   // ************************************************************
   // one pin, four meanings; write bursts take priority over read bursts
   always_comb begin
      if (udma_in.wr_active) begin
         nxt_flow = ~udma_in.wr_can_accept;
      end else if (udma_in.rd_active) begin
         nxt_flow = dstrobe_ff;
      end else if (mode_in == MODE_ATA) begin
         nxt_flow = ~status_in.access_stall;
      end else begin
         nxt_flow = ~status_in.access_stall;
      end
   end

   // ************************************************************
   // status pin
   // ************************************************************
   // before initialisation is done the write-protect level stays high
   always_comb begin
      case (mode_in)
         MODE_MEM: nxt_stat = ~status_in.init_done;
         MODE_IO:  nxt_stat = ~status_in.port16;
         MODE_ATA: nxt_stat = ~status_in.word_xfer;
         default:  nxt_stat = `PIN_HIGH;
      endcase
   end

   // registered pin drivers; both pins are driven by the card whenever out of reset
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         flow_out    <= `PIN_HIGH;
         flow_oe_out <= `PIN_LOW;
         stat_out    <= `PIN_HIGH;
         stat_oe_out <= `PIN_LOW;
      end else begin
         flow_out    <= nxt_flow;
         flow_oe_out <= `PIN_HIGH;
         stat_out    <= nxt_stat;
         stat_oe_out <= `PIN_HIGH;
      end
   end

endmodule : cf_host_port

// ---- cf_host_port_defs.svh ----
/*
 * Constants of the card-side host port: clock rate, burst timing and pin levels.
 * Assumes it is included by its bare name by the package and the design modules.
 */
`ifndef CF_HOST_PORT_DEFS_SVH
`define CF_HOST_PORT_DEFS_SVH

// ************************************************************
// clock
// ************************************************************
`define SYS_CLK_MHZ          200

// ************************************************************
// read burst timing, in ns as budgeted for the data-in strobe
// ************************************************************
`define RD_SETUP_NS          20
`define RD_HOLD_NS           15
// least times round up to whole cycles
`define RD_SETUP_CYC         ((`RD_SETUP_NS * `SYS_CLK_MHZ + 999) / 1000)
`define RD_HOLD_CYC          ((`RD_HOLD_NS * `SYS_CLK_MHZ + 999) / 1000)
`define TMR_W                8

// ************************************************************
// pin levels and widths
// ************************************************************
`define DATA_W               16
`define PIN_LOW              1'h0
`define PIN_HIGH             1'h1
`define SYNC_STAGES          2

`endif

// ---- cf_host_port_pkg.sv ----
/*
 * Types shared by the card-side host port modules.
 * Assumes cf_host_port_defs.svh is on the include path.
 */
`include "cf_host_port_defs.svh"

package cf_host_port_pkg;

   // ************************************************************
   // operating personality of the card
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_MEM = 2'b00,
      MODE_IO  = 2'b01,
      MODE_ATA = 2'b10
   } mode_e;

   // one data word with its valid flag
   typedef struct packed {
      logic                 valid;
      logic [`DATA_W-1:0]   data;
   } word_s;

   // core status that steers the flow-control and status pins
   typedef struct packed {
      logic init_done;
      logic access_stall;
      logic port16;
      logic word_xfer;
   } core_status_s;

   // ultra dma burst control from the core
   typedef struct packed {
      logic wr_active;
      logic rd_active;
      logic wr_can_accept;
   } udma_ctrl_s;

endpackage : cf_host_port_pkg

// ---- cf_host_port_sva.sv ----
/*
 * Concurrent checks on the host port flow, strobe and status pins.
 * Assumes one clock domain and the pin timing of the hand-over contract.
 */
`timescale 1ns/1ps

module cf_host_port_sva
   import cf_host_port_pkg::*;
(
   // clock and reset
   input wire logic         clk_sys_in,
   input wire logic         rstn_in,
   // core side
   input wire mode_e        mode_in,
   input wire core_status_s status_in,
   input wire udma_ctrl_s   udma_in,
   input wire word_s        rd_word_in,
   input wire logic         rd_taken_out,
   input wire logic         cfg_wr_out,
   input wire logic         task_wr_out,
   // host pins
   input wire logic         we_n_in,
   input wire logic         flow_out,
   input wire logic         stat_out
);
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);

   // neither burst direction running
   logic no_dma;
   assign no_dma = !udma_in.wr_active && !udma_in.rd_active;

   sequence s_rd_hold;
      udma_in.rd_active && !udma_in.wr_active && !rd_word_in.valid;
   endsequence
   sequence s_mem_we;
      mode_in == MODE_MEM && no_dma && $fell(we_n_in);
   endsequence

   property p_stall; no_dma && status_in.access_stall |=> !flow_out; endproperty
   a_stall: assert property (p_stall) else $error("stall not on flow pin");
   property p_release; no_dma && !status_in.access_stall |=> flow_out; endproperty
   a_release: assert property (p_release) else $error("flow pin not released");
   property p_wr_rdy; udma_in.wr_active |=> flow_out == !$past(udma_in.wr_can_accept); endproperty
   a_wr_rdy: assert property (p_wr_rdy) else $error("write ready wrong");
   property p_wp; mode_in == MODE_MEM |=> stat_out == !$past(status_in.init_done); endproperty
   a_wp: assert property (p_wp) else $error("protect level wrong");
   property p_io16; mode_in == MODE_IO |=> stat_out == !$past(status_in.port16); endproperty
   a_io16: assert property (p_io16) else $error("port width level wrong");
   property p_word; mode_in == MODE_ATA |=> stat_out == !$past(status_in.word_xfer); endproperty
   a_word: assert property (p_word) else $error("word cycle level wrong");
   property p_ata_we; mode_in == MODE_ATA [*5] |-> !cfg_wr_out && !task_wr_out; endproperty
   a_ata_we: assert property (p_ata_we) else $error("write strobe not ignored");
   property p_io_we; mode_in == MODE_IO [*5] |-> !task_wr_out; endproperty
   a_io_we: assert property (p_io_we) else $error("task write in io mode");
   property p_mem_we; s_mem_we |-> ##[2:5] (cfg_wr_out || task_wr_out); endproperty
   a_mem_we: assert property (p_mem_we) else $error("memory write lost");
   property p_strobe; rd_taken_out |-> ##[3:6] $changed(flow_out); endproperty
   a_strobe: assert property (p_strobe) else $error("no strobe edge");
   property p_pause; s_rd_hold [*8] |=> $stable(flow_out); endproperty
   a_pause: assert property (p_pause) else $error("strobe moved in pause");
endmodule : cf_host_port_sva

bind cf_host_port cf_host_port_sva u_sva (
   .clk_sys_in, .rstn_in, .mode_in, .status_in, .udma_in, .rd_word_in,
   .rd_taken_out, .cfg_wr_out, .task_wr_out, .we_n_in, .flow_out, .stat_out
);

// ---- cf_host_port_tb_top.sv ----
/*
 * Self-checking bench for the host port flow, strobe and status pins.
 * Assumes host_model and the bound checker are compiled before it.
 */
`timescale 1ns/1ps
`include "cf_host_port_defs.svh"

module cf_host_port_tb_top import cf_host_port_pkg::*;;
   // ************************************************************
   // signals and instances
   // ************************************************************
   typedef struct packed {mode_e m; core_status_s st; udma_ctrl_s ud; logic fl; logic sa;} row_s;

   logic               clk_sys_in, rstn_in, rd_taken_out, cfg_wr_out, task_wr_out;
   logic               we_n_in, dmack_n_in, hstrobe_in, hdmardy_n_in, held;
   logic               data_oe_out, flow_out, flow_oe_out, stat_out, stat_oe_out;
   mode_e              mode_in;
   core_status_s       status_in;
   udma_ctrl_s         udma_in;
   word_s              rd_word_in, wr_word_out;
   logic [`DATA_W-1:0] data_in, data_out, host_data, n_cfg, n_task;
   logic [`DATA_W-1:0] w[4];
   int                 error_cnt, checks;

   // ordinary cases: both pins per personality, status and burst
   row_s rows[8] = '{
      '{MODE_MEM, 4'h8, 3'h0, 1'h1, 1'h0}, '{MODE_MEM, 4'h4, 3'h0, 1'h0, 1'h1},
      '{MODE_IO, 4'h6, 3'h0, 1'h0, 1'h0}, '{MODE_IO, 4'h9, 3'h0, 1'h1, 1'h1},
      '{MODE_ATA, 4'h5, 3'h0, 1'h0, 1'h0}, '{MODE_ATA, 4'hA, 3'h0, 1'h1, 1'h1},
      '{MODE_ATA, 4'h4, 3'h5, 1'h0, 1'h1}, '{MODE_MEM, 4'h8, 3'h4, 1'h1, 1'h0}};

   cf_host_port u_dut (
      .clk_sys_in, .rstn_in, .mode_in, .status_in, .udma_in, .rd_word_in, .rd_taken_out,
      .wr_word_out, .cfg_wr_out, .task_wr_out, .we_n_in, .dmack_n_in, .hstrobe_in,
      .hdmardy_n_in, .data_in, .data_out, .data_oe_out, .flow_out, .flow_oe_out,
      .stat_out, .stat_oe_out);
   host_model u_host (
      .flow_in(flow_out), .bus_in(data_out), .bus_oe_in(data_oe_out), .we_n_out(we_n_in),
      .dmack_n_out(dmack_n_in), .hstrobe_out(hstrobe_in), .hdmardy_n_out(hdmardy_n_in),
      .data_out(host_data));
   // shared data bus: the card wins while it drives
   assign data_in = data_oe_out ? data_out : host_data;

   initial begin
      clk_sys_in = 1'h0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // ************************************************************
   // compare, wait and verdict
   // ************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask : tick

   task automatic final_report();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   // hang guard: a stuck run ends as a failure
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      error_cnt++;
      final_report();
   end

   initial begin
      rstn_in = 1'h0;
      mode_in = MODE_MEM;
      status_in = '0;
      udma_in = '0;
      rd_word_in = '0;
      w = '{16'h1234, 16'hABCD, 16'h0F0F, 16'hF0F0};
      tick(3);
      check(16'({flow_out, stat_out}), 16'h0003);
      check(16'({flow_oe_out, stat_oe_out, data_oe_out}), 16'h0000);
      tick(3);
      rstn_in = 1'h1;
      tick(2);
      check(16'({flow_oe_out, stat_oe_out}), 16'h0003);
      foreach (rows[i]) begin
         mode_in = rows[i].m;
         status_in = rows[i].st;
         udma_in = rows[i].ud;
         tick(2);
         check(16'(flow_out), 16'(rows[i].fl));
         check(16'(stat_out), 16'(rows[i].sa));
      end
      // write strobe per personality; ATA mode ignores it
      status_in = 4'h8;
      udma_in = '0;
      for (int m = 0; m < 3; m++) begin
         mode_in = mode_e'(m);
         n_cfg = '0;
         n_task = '0;
         tick(6);
         fork
            u_host.we_pulse();
         join_none
         repeat (20) begin
            @(negedge clk_sys_in);
            n_cfg += 16'(cfg_wr_out);
            n_task += 16'(task_wr_out);
         end
         check(n_cfg, (m == 2) ? 16'h0000 : 16'h0001);
         check(n_task, (m == 0) ? 16'h0001 : 16'h0000);
      end
      // write burst, the card pausing it after the second word
      mode_in = MODE_ATA;
      status_in = '0;
      udma_in = 3'h5;
      tick(4);
      fork
         u_host.wr_burst(w);
      join_none
      n_cfg = '0;
      for (int k = 0; k < 400 && n_cfg < 4; k++) begin
         @(negedge clk_sys_in);
         udma_in.wr_can_accept = (k < 30 || k > 70);
         if (k == 50) check(16'(flow_out), 16'h0001);
         if (wr_word_out.valid === 1'h1) begin
            check(wr_word_out.data, w[n_cfg[1:0]]);
            n_cfg += 16'h0001;
         end
      end
      check(n_cfg, 16'h0004);
      udma_in = '0;
      tick(20);
      // read burst of four words, paused after the second
      udma_in = 3'h2;
      u_host.rd_enable(1'h1);
      tick(4);
      rd_word_in = {1'h1, w[0]};
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 40 && rd_taken_out !== 1'h1; k++) @(negedge clk_sys_in);
         // a take that never comes ends the run as a failure
         if (rd_taken_out !== 1'h1) begin
            error_cnt++;
            final_report();
         end
         rd_word_in = (i == 1 || i == 3) ? '0 : {1'h1, w[(i + 1) % 4]};
         tick(1);
         if (i == 1) begin
            tick(12);
            held = flow_out;
            tick(8);
            check(16'(flow_out), 16'(held));
            rd_word_in = {1'h1, w[2]};
         end
      end
      tick(12);
      u_host.rd_enable(1'h0);
      udma_in = '0;
      check(16'(u_host.got.size()), 16'h0004);
      foreach (u_host.got[i]) check(u_host.got[i], w[i]);
      // mid-run reset: pins fall back to idle levels, then come back driven
      mode_in = MODE_IO;
      status_in = 4'h2;
      tick(2);
      rstn_in = 1'h0;
      tick(2);
      check(16'({flow_out, stat_out, flow_oe_out, stat_oe_out, data_oe_out}), 16'h0018);
      rstn_in = 1'h1;
      tick(2);
      check(16'({flow_out, stat_out, flow_oe_out, stat_oe_out}), 16'h000B);
      final_report();
   end
endmodule : cf_host_port_tb_top

// ---- host_model.sv ----
/*
 * Behavioural host controller driving the card's host pins.
 * Assumes the bench calls one task at a time; the pins have no clock.
 */
`timescale 1ns/1ps
`include "cf_host_port_defs.svh"

module host_model (
   // card pins
   input  wire logic               flow_in,
   input  wire logic [`DATA_W-1:0] bus_in,
   input  wire logic               bus_oe_in,
   // host pins
   output logic                    we_n_out,
   output logic                    dmack_n_out,
   output logic                    hstrobe_out,
   output logic                    hdmardy_n_out,
   output logic [`DATA_W-1:0]      data_out
);
   // ************************************************************
   // drive and capture
   // ************************************************************
   logic               capture;
   logic [`DATA_W-1:0] got[$];

   // idle levels; write strobe held high when unused
   initial begin
      we_n_out = 1'h1;
      dmack_n_out = 1'h1;
      hstrobe_out = 1'h1;
      hdmardy_n_out = 1'h1;
      data_out = 16'h5AA5;
      capture = 1'h0;
   end

   // a word on each strobe edge; no edge means a pause
   always @(flow_in) begin
      if (capture && bus_oe_in) got.push_back(bus_in);
   end

   // 1.25 ns offsets keep host edges off the card clock edges
   task automatic we_pulse();
      #1.25 we_n_out = 1'h0;
      #62.5 we_n_out = 1'h1;
   endtask : we_pulse

   task automatic rd_enable(input logic on);
      capture = on;
      dmack_n_out = !on;
      hdmardy_n_out = !on;
   endtask : rd_enable

   // every word waits for ready; strobe period 125 ns
   task automatic wr_burst(input logic [`DATA_W-1:0] w[4]);
      dmack_n_out = 1'h0;
      #61.25;
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 400 && flow_in; k++) #5;
         data_out = w[i];
         #10 hstrobe_out = ~hstrobe_out;
         #52.5;
      end
      data_out = ~data_out; // released bus must not repeat the last word
      dmack_n_out = 1'h1;
   endtask : wr_burst
endmodule : host_model

// ---- phase_timer.sv ----
/*
 * Down counter that times one phase of a read burst.
 * Assumes start is a one-cycle pulse; done is high while the count is zero.
 */
`timescale 1ns/1ps
`include "cf_host_port_defs.svh"

module phase_timer (
   // clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              rstn_in,
   // control
   input  wire logic              start_in,
   input  wire logic [`TMR_W-1:0] load_in,
   output logic                   done_out
);

   logic [`TMR_W-1:0] cnt_ff;

   // count down to zero after each start
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_ff <= '0;
      end else if (start_in) begin
         cnt_ff <= load_in;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - `TMR_W'(1);
      end
   end

   assign done_out = (cnt_ff == '0);

endmodule : phase_timer

// ---- sync_pin.sv ----
/*
 * Two-stage synchroniser for a group of pins coming from the host.
 * Assumes inputs are asynchronous to clk_sys_in; the first stage feeds only the second.
 */
`timescale 1ns/1ps
`include "cf_host_port_defs.svh"

module sync_pin #(
   parameter int         WIDTH     = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             rstn_in,
   // pin group
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;

   // first stage is read only by the second
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_ff  <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_ff  <= pin_in;
         sync_out <= meta_ff;
      end
   end

endmodule : sync_pin
